// ---- gpio_port_pkg.sv ----
// constants, types and register map of the four-pin gpio port
// assumes an ahb-lite master with word transfers and one clock, hclk
`default_nettype none

package gpio_port_pkg;

  localparam int          PIN_COUNT      = 4;
  localparam int          REG_WIDTH      = 8;
  localparam int          INDEX_WIDTH    = 16;
  localparam int          INDEX_LSB      = 2;

  // printed offsets are not word aligned: each is an index, byte address is index * 4
  localparam logic [15:0] DATA_INDEX     = 16'hFFDD;
  localparam logic [15:0] DIR_INDEX      = 16'hFFED;
  localparam logic [15:0] LCD_CTRL_INDEX = 16'hFFC0;

  localparam logic [7:0]  DATA_RESET     = 8'hF0;
  localparam logic [7:0]  DIR_RESET      = 8'hF0;
  localparam logic [7:0]  DIR_READ_VALUE = 8'hFF;
  localparam logic [7:0]  LCD_CTRL_RESET = 8'h00;
  localparam logic [3:0]  UPPER_ONES     = 4'hF;
  localparam logic [3:0]  SEG_SEL_GPIO   = 4'h0;
  localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;

  localparam int          SEG_SEL_LSB    = 0;
  localparam int          SEG_SEL_WIDTH  = 4;

  localparam logic [1:0]  HTRANS_IDLE    = 2'h0;
  localparam int          HTRANS_ACTIVE  = 1;
  localparam logic        HRESP_OKAY     = 1'h0;

  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_SUBACTIVE,
    MODE_SLEEP,
    MODE_SUBSLEEP,
    MODE_WATCH,
    MODE_STANDBY
  } power_mode_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
  } bus_req_t;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] enable;
  } pin_drive_t;

endpackage

`default_nettype wire

// ---- gpio_pin_cell.sv ----
// output stage of one port pin: picks gpio or lcd common, floats or holds per power mode
// assumes inputs synchronous to hclk; outputs are flops
`default_nettype none

module gpio_pin_cell (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic lcd_owned,
  input  wire logic dir_bit,
  input  wire logic data_bit,
  input  wire logic lcd_level,
  input  wire logic hold,
  input  wire logic float_pin,
  output var  logic pin_out_q,
  output var  logic pin_oe_q
);

  logic pin_out_d;
  logic pin_oe_d;

  // lcd common wins regardless of direction
  assign pin_out_d = hold ? pin_out_q :
                     lcd_owned ? lcd_level : data_bit; // [R11] [R14]
  assign pin_oe_d  = float_pin ? 1'b0 :
                     hold ? pin_oe_q :
                     (lcd_owned | dir_bit); // [R6] [R12]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_q <= 1'b0;
      pin_oe_q  <= 1'b0; // [R12]
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
    end
  end

endmodule // gpio_pin_cell

`default_nettype wire

// ---- gpio_port.sv ----
// four-pin general purpose port with direction and data registers on ahb-lite
// assumes one ahb-lite master, word transfers, pins synchronous to hclk
//
// Operation
// [R1] four bidirectional pins, each input or output
// [R2] data register eight bits, pins in 3:0
// [R3] data and direction at fixed index addresses
// [R4] output pin reads latched data bit
// [R5] input pin reads live pin level
// [R6] direction one output, zero input
// [R7] settings apply only to gpio-assigned pins
// [R8] data register resets to F0
// [R9] direction register resets to F0, inputs
// [R10] direction write only, reads all ones
// [R11] segment select zero gpio, else lcd common
// [R12] float in reset/standby, hold in sleeps
// [R13] data upper nibble ignores writes, reads ones
// [R14] output pin drives data bit next cycle
`default_nettype none

module gpio_port (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output var  logic [31:0]                hrdata,
  output var  logic                       hreadyout,
  output var  logic                       hresp,
  input  wire gpio_port_pkg::power_mode_t power_mode,
  input  wire logic [3:0]                 lcd_common,
  input  wire logic [3:0]                 gpio_in,
  output var  logic [3:0]                 gpio_out,
  output var  logic [3:0]                 gpio_oe
);

  // register index decode, shared by write and read paths
  function automatic logic index_hit(input logic [15:0] idx, input logic [15:0] target);
    index_hit = (idx == target);
  endfunction

  gpio_port_pkg::bus_req_t   req_q;
  gpio_port_pkg::bus_req_t   req_d;
  gpio_port_pkg::pin_drive_t drive;

  logic [3:0]  data_bits_q;
  logic [3:0]  data_bits_d;
  logic [3:0]  dir_bits_q;
  logic [3:0]  dir_bits_d;
  logic [7:0]  lcd_ctrl_q;
  logic [7:0]  lcd_ctrl_d;
  logic [31:0] hrdata_d;

  logic [15:0] addr_index;
  logic        addr_phase;
  logic        wr_commit;
  logic        wr_data;
  logic        wr_dir;
  logic        wr_lcd;
  logic        rd_data;
  logic        rd_dir;
  logic        rd_lcd;
  logic [3:0]  seg_sel;
  logic        lcd_owned;
  logic [3:0]  pin_gpio;
  logic [3:0]  port_read;
  logic        hold_pins;
  logic        float_pins;

  // address phase capture; slave is zero wait so hready only gates the master's phase
  assign addr_index = haddr[gpio_port_pkg::INDEX_LSB +: gpio_port_pkg::INDEX_WIDTH];
  assign addr_phase = hsel & hready & htrans[gpio_port_pkg::HTRANS_ACTIVE];

  assign req_d.valid = addr_phase;
  assign req_d.write = hwrite;
  assign req_d.index = addr_index;

  // data phase write decode
  assign wr_commit = req_q.valid & req_q.write;
  assign wr_data   = wr_commit & index_hit(req_q.index, gpio_port_pkg::DATA_INDEX); // [R3]
  assign wr_dir    = wr_commit & index_hit(req_q.index, gpio_port_pkg::DIR_INDEX); // [R3]
  assign wr_lcd    = wr_commit & index_hit(req_q.index, gpio_port_pkg::LCD_CTRL_INDEX);

  // only the low nibble is stored; upper data bits are constant ones
  assign data_bits_d = wr_data ? hwdata[gpio_port_pkg::PIN_COUNT-1:0] : data_bits_q; // [R2] [R13]
  assign dir_bits_d  = wr_dir ? hwdata[gpio_port_pkg::PIN_COUNT-1:0] : dir_bits_q; // [R6]
  assign lcd_ctrl_d  = wr_lcd ? {4'h0, hwdata[gpio_port_pkg::SEG_SEL_WIDTH-1:0]} : lcd_ctrl_q;

  // pin sharing with lcd commons
  assign seg_sel   = lcd_ctrl_q[gpio_port_pkg::SEG_SEL_LSB +: gpio_port_pkg::SEG_SEL_WIDTH];
  assign lcd_owned = (seg_sel != gpio_port_pkg::SEG_SEL_GPIO); // [R11] [R7]

  // power mode handling of the pins
  assign float_pins = (power_mode == gpio_port_pkg::MODE_STANDBY); // [R12]
  assign hold_pins  = (power_mode == gpio_port_pkg::MODE_SLEEP) |
                      (power_mode == gpio_port_pkg::MODE_SUBSLEEP) |
                      (power_mode == gpio_port_pkg::MODE_WATCH); // [R12]

  // read path: the next register values are used so a read right after a write sees it
  genvar g;
  generate
    for (g = 0; g < gpio_port_pkg::PIN_COUNT; g++) begin : g_pin
      assign port_read[g] = dir_bits_d[g] ? data_bits_d[g] : gpio_in[g]; // [R4] [R5]
      assign pin_gpio[g]  = drive.level[g];

      gpio_pin_cell u_cell (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .lcd_owned (lcd_owned),
        .dir_bit   (dir_bits_q[g]),
        .data_bit  (data_bits_q[g]),
        .lcd_level (lcd_common[g]),
        .hold      (hold_pins),
        .float_pin (float_pins),
        .pin_out_q (drive.level[g]),
        .pin_oe_q  (drive.enable[g])
      ); // [R1]
    end
  endgenerate

  assign rd_data = index_hit(addr_index, gpio_port_pkg::DATA_INDEX);
  assign rd_dir  = index_hit(addr_index, gpio_port_pkg::DIR_INDEX);
  assign rd_lcd  = index_hit(addr_index, gpio_port_pkg::LCD_CTRL_INDEX);

  assign hrdata_d = !(addr_phase & !hwrite) ? hrdata :
                    rd_data ? {24'h0, gpio_port_pkg::UPPER_ONES, port_read} : // [R13]
                    rd_dir  ? {24'h0, gpio_port_pkg::DIR_READ_VALUE} : // [R10]
                    rd_lcd  ? {24'h0, lcd_ctrl_d} :
                    gpio_port_pkg::UNMAPPED_READ;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else begin
      req_q <= req_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_bits_q <= gpio_port_pkg::DATA_RESET[3:0]; // [R8]
      dir_bits_q  <= gpio_port_pkg::DIR_RESET[3:0]; // [R9]
      lcd_ctrl_q  <= gpio_port_pkg::LCD_CTRL_RESET;
    end else begin
      data_bits_q <= data_bits_d;
      dir_bits_q  <= dir_bits_d;
      lcd_ctrl_q  <= lcd_ctrl_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= gpio_port_pkg::UNMAPPED_READ;
      hreadyout <= 1'b1;
      hresp     <= gpio_port_pkg::HRESP_OKAY;
    end else begin
      hrdata    <= hrdata_d;
      hreadyout <= 1'b1;
      hresp     <= gpio_port_pkg::HRESP_OKAY;
    end
  end

  // pin outputs already come from flops inside the cells
  always_comb begin
    gpio_out = pin_gpio;
    gpio_oe  = drive.enable;
  end

endmodule // gpio_port

`default_nettype wire

// ---- gpio_port_tail_note_unused.sv ----
`default_nettype none
`default_nettype wire

// ---- gpio_port_chk.sv ----
// assertions on the port pins and read data, watching only top-level ports
// assumes whole-word single ahb-lite transfers and hready tied to hreadyout
`default_nettype none
module gpio_port_chk (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [31:0]                hwdata,
  input wire logic                       hready,
  input wire logic [31:0]                hrdata,
  input wire gpio_port_pkg::power_mode_t power_mode,
  input wire logic [3:0]                 lcd_common,
  input wire logic [3:0]                 gpio_in,
  input wire logic [3:0]                 gpio_out,
  input wire logic [3:0]                 gpio_oe
);
  logic [15:0] wa_q;
  logic [3:0]  dir_q, dat_q, seg_q;
  wire         take   = hsel & hready & htrans[1];
  wire [15:0]  idx    = haddr[17:2];
  wire         rd_dat = take & !hwrite & idx == gpio_port_pkg::DATA_INDEX;
  wire         rd_dir = take & !hwrite & idx == gpio_port_pkg::DIR_INDEX;
  wire         act    = power_mode == gpio_port_pkg::MODE_ACTIVE;
  wire         hold   = power_mode inside {gpio_port_pkg::MODE_SLEEP, gpio_port_pkg::MODE_SUBSLEEP,
                                           gpio_port_pkg::MODE_WATCH};
  // a write in its data phase lands at the same edge as a back-to-back read address phase
  wire [3:0]   dir_nx = (wa_q == gpio_port_pkg::DIR_INDEX) ? hwdata[3:0] : dir_q;
  wire [3:0]   dat_nx = (wa_q == gpio_port_pkg::DATA_INDEX) ? hwdata[3:0] : dat_q;
  wire [3:0]   mix    = dir_nx & dat_nx | ~dir_nx & gpio_in;
  // shadow registers: the direction register cannot be read back, so it is rebuilt from bus writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wa_q  <= 16'h0;
      dir_q <= 4'h0;
      dat_q <= 4'h0;
      seg_q <= 4'h0;
    end else begin
      wa_q <= (take && hwrite) ? idx : 16'h0;
      if (wa_q == gpio_port_pkg::DATA_INDEX) dat_q <= hwdata[3:0];
      if (wa_q == gpio_port_pkg::DIR_INDEX) dir_q <= hwdata[3:0];
      if (wa_q == gpio_port_pkg::LCD_CTRL_INDEX) seg_q <= hwdata[3:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_STANDBY_FLOAT: assert property (power_mode == gpio_port_pkg::MODE_STANDBY |=> gpio_oe == 4'h0)
    else $error("pin driven in standby");
  AST_SLEEP_HOLD: assert property (hold |=> $stable({gpio_out, gpio_oe}))
    else $error("pin changed while held");
  AST_RESET_FLOAT: assert property ($rose(hresetn) |-> gpio_oe == 4'h0 && gpio_out == 4'h0)
    else $error("pin driven after reset");
  AST_DIR_READ: assert property (rd_dir |=> hrdata == 32'h0000_00FF)
    else $error("direction read not all ones");
  AST_DATA_UPPER: assert property (rd_dat |=> hrdata[31:4] == 28'h000_000F)
    else $error("data upper bits wrong");
  AST_READ_MIX: assert property (rd_dat |=> hrdata[3:0] == $past(mix))
    else $error("data read mixes pins wrongly");
  AST_LCD_DRIVE: assert property (seg_q != 4'h0 && act |=>
    gpio_oe == 4'hF && gpio_out == $past(lcd_common))
    else $error("lcd common not driven");
  AST_GPIO_DRIVE: assert property (seg_q == 4'h0 && act |=>
    gpio_oe == $past(dir_q) && gpio_out == $past(dat_q))
    else $error("gpio output wrong");
  cover property (rd_dir);
  cover property (seg_q != 4'h0 && act);
  cover property (power_mode == gpio_port_pkg::MODE_STANDBY);
endmodule // gpio_port_chk
bind gpio_port gpio_port_chk i_gpio_port_chk (.*);
`default_nettype wire

// ---- gpio_pins_model.sv ----
// board side of the four port pins
// assumes board_level is what the board puts on pins that the port releases
`default_nettype none
module gpio_pins_model (
  input  wire logic [3:0] gpio_out,
  input  wire logic [3:0] gpio_oe,
  input  wire logic [3:0] board_level,
  output var  logic [3:0] gpio_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // a driven pin reads back its own level, a released one follows the board
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & board_level);
endmodule // gpio_pins_model
`default_nettype wire

// ---- tb_gpio_port.sv ----
// register and pin tests of the gpio port over ahb-lite
// assumes the board model on the pins and a 100 ns clock
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module tb_gpio_port;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] DI = gpio_port_pkg::DATA_INDEX;
  localparam logic [15:0] RI = gpio_port_pkg::DIR_INDEX;
  localparam logic [15:0] LI = gpio_port_pkg::LCD_CTRL_INDEX;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [3:0]  lcd_common = 4'h0, board_level = 4'h0, gpio_in, gpio_out, gpio_oe;
  gpio_port_pkg::power_mode_t power_mode = gpio_port_pkg::MODE_ACTIVE;
  int          err_total = 0;
  int          n_checks = 0;
  always #50 hclk = ~hclk;
  assign hready = hreadyout;
  gpio_port i_gpio_port (.*);
  gpio_pins_model i_gpio_pins_model (.*);
  // waits on hready with no cycle limit of its own: a stuck bus is ended by the watchdog
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= gpio_port_pkg::HTRANS_IDLE;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    `CHK(rd, exp)
    `CHK(hresp, gpio_port_pkg::HRESP_OKAY)
  endtask
  // outputs are flops fed by the registers, so two edges pass before they show a write
  task automatic pins(input logic [3:0] oe, input logic [3:0] out);
    repeat (2) @(posedge hclk);
    `CHK(gpio_oe, oe)
    `CHK(gpio_out, out)
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK(gpio_oe, 4'h0)
    rchk(DI, 32'h0000_00F0);
    rchk(RI, 32'h0000_00FF);
    rchk(16'h0100, gpio_port_pkg::UNMAPPED_READ);
    $display("test reset done");
    xfer(1'b1, RI, 32'h0000_000F);
    rchk(DI, 32'h0000_00F0);
    xfer(1'b1, DI, 32'h0000_005A);
    rchk(DI, 32'h0000_00FA);
    rchk(RI, 32'h0000_00FF);
    pins(4'hF, 4'hA);
    $display("test outputs done");
    board_level <= 4'h5;
    xfer(1'b1, RI, 32'h0000_0003);
    // released pins keep driving the data bits on gpio_out; only their enables fall
    pins(4'h3, 4'hA);
    rchk(DI, 32'h0000_00F6);
    $display("test mixed done");
    lcd_common <= 4'h9;
    xfer(1'b1, LI, 32'h0000_0001);
    pins(4'hF, 4'h9);
    rchk(DI, 32'h0000_00FA);
    xfer(1'b1, LI, 32'h0000_0000);
    pins(4'h3, 4'hA);
    $display("test lcd done");
    // sleep, subsleep and watch in turn: a write must not reach the pins
    for (int m = 2; m < 5; m++) begin
      power_mode <= gpio_port_pkg::power_mode_t'(m);
      xfer(1'b1, DI, m);
      pins(4'h3, 4'hA);
    end
    power_mode <= gpio_port_pkg::MODE_SUBACTIVE;
    pins(4'h3, 4'h4);
    power_mode <= gpio_port_pkg::MODE_STANDBY;
    repeat (2) @(posedge hclk);
    `CHK(gpio_oe, 4'h0)
    power_mode <= gpio_port_pkg::MODE_ACTIVE;
    pins(4'h3, 4'h4);
    $display("test power done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK(gpio_oe, 4'h0)
    xfer(1'b1, RI, 32'h0000_000F);
    rchk(DI, 32'h0000_00F0);
    $display("test second reset done");
    tally_and_finish;
  end
endmodule // tb_gpio_port
`default_nettype wire
